// *** logic/xmem_defs.svh ***
// Constants of the external memory interface
// Contract
// R1: Program space spans full 16-bit range
// R2: Fetch starts at address zero after reset
// R3: Vectors at three, spaced eight bytes; only constants here, no logic generates vector addresses
// R4: Decode four populated external data regions
// R5: Writes only from external move to memory
// R6: Low three stretch bits select stretch
// R7: Read address and strobe stretch+1 cycles
// R8: Write address stretch+2, strobe max(stretch,1)
// R9: Stretch resets to one
// R10: Paged move: index low, page register high
// R11: Pointer move drives full pointer address
// R12: Select bit zero picks active pointer
// R13: Pointer instructions act on selected pointer
// R14: Core clock divided by three-bit field
// R15: Unpopulated reads harmless, writes ignored
`ifndef XMEM_DEFS_SVH
`define XMEM_DEFS_SVH

// ----------------------------------------------------------------
// Register map (APB byte offsets)
// ----------------------------------------------------------------
`define OFF_STRETCH    12'h000
`define OFF_PTR_SEL    12'h004
`define OFF_PAGE_HIGH  12'h008
`define OFF_PTR0       12'h00C
`define OFF_PTR1       12'h010
`define OFF_INDEX      12'h014
`define OFF_CLK_DIV    12'h018
`define OFF_CMD        12'h01C
`define OFF_STATUS     12'h020
`define OFF_CODE_ADDR  12'h024

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define STRETCH_RST    3'h1
`define STRETCH_MAX    3'h7
`define RESET_VECTOR   16'h0000
`define VECTOR_BASE    16'h0003
`define VECTOR_STEP    16'h0008
`define CMD_OP_LSB     0
`define CMD_OP_MSB     2
`define CMD_DATA_LSB   8
`define CMD_DATA_MSB   15

// ----------------------------------------------------------------
// Region bounds
// ----------------------------------------------------------------
`define GRAM_LO        16'h0000
`define GRAM_HI        16'h07FF
`define EDRAM_LO       16'h1000
`define EDRAM_HI       16'h13FF
`define IORAM_LO       16'h2000
`define IORAM_HI       16'h20FF
`define EPRAM_LO       16'h3000
`define EPRAM_HI       16'h3FFF
`define UNMAPPED_DATA  8'hFF

`endif

// *** logic/xmem_pkg.sv ***
// Types of the external memory interface
package xmem_pkg;
    typedef enum logic [2:0] {
        OP_NONE       = 3'b000,
        OP_READ_PAGED = 3'b001,
        OP_READ_PTR   = 3'b010,
        OP_WRITE_PAGED= 3'b011,
        OP_WRITE_PTR  = 3'b100,
        OP_PTR_INC    = 3'b101,
        OP_PTR_LOAD   = 3'b110
    } op_t;

    typedef enum logic [2:0] {
        REGION_NONE  = 3'b000,
        REGION_GRAM  = 3'b001,
        REGION_EDRAM = 3'b010,
        REGION_IORAM = 3'b011,
        REGION_EPRAM = 3'b100
    } region_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ADDR  = 2'b01,
        ST_HOLD  = 2'b10
    } state_t;
endpackage

// *** logic/xmem_timing_if.sv ***
// Strobe timing link between controller and timer
`timescale 1ns/1ps
interface xmem_timing_if;
    logic       start;
    logic       write;
    logic [2:0] stretch;
    logic       busy;
    logic       addr_phase;
    logic       strobe;
    logic       done;
    modport ctrl  (output start, output write, output stretch,
                   input busy, input addr_phase, input strobe, input done);
    modport timer (input start, input write, input stretch,
                   output busy, output addr_phase, output strobe, output done);
endinterface

// *** logic/xmem_strobe_timer.sv ***
// Address phase and strobe width generator
`timescale 1ns/1ps
`include "xmem_defs.svh"
module xmem_strobe_timer
(
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    input  wire logic            i_ce,
    xmem_timing_if.timer         tif
);
    logic [3:0] addr_cnt_q;
    logic [3:0] strb_cnt_q;
    logic       write_q;

    // Counts run only on core clock enables
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            addr_cnt_q <= 4'h0;
            strb_cnt_q <= 4'h0;
            write_q    <= 1'b0;
        end
        else if (tif.start)
        begin
            write_q <= tif.write;
            if (tif.write)
            begin
                addr_cnt_q <= {1'b0, tif.stretch} + 4'h2;               // [R8]
                strb_cnt_q <= (tif.stretch == 3'h0) ? 4'h1
                              : {1'b0, tif.stretch};                   // [R8]
            end
            else
            begin
                addr_cnt_q <= {1'b0, tif.stretch} + 4'h1;               // [R7]
                strb_cnt_q <= {1'b0, tif.stretch} + 4'h1;               // [R7]
            end
        end
        else if (i_ce && addr_cnt_q != 4'h0)
        begin
            addr_cnt_q <= addr_cnt_q - 4'h1;
            if (strb_cnt_q != 4'h0)
                strb_cnt_q <= strb_cnt_q - 4'h1;
        end
    end

    assign tif.busy       = (addr_cnt_q != 4'h0);
    assign tif.addr_phase = (addr_cnt_q != 4'h0);
    assign tif.strobe     = (strb_cnt_q != 4'h0);
    assign tif.done       = i_ce && (addr_cnt_q == 4'h1);
endmodule

// *** logic/xmem_controller.sv ***
// External data memory controller with APB registers
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "xmem_defs.svh"
module xmem_controller
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [7:0]  i_mem_rdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic      [15:0] o_mem_addr,
    output logic      [7:0]  o_mem_wdata,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic      [4:0]  o_mem_sel,
    output logic      [15:0] o_code_addr,
    output logic             o_core_ce
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [2:0]  stretch_q;
    logic        ptr_sel_q;
    logic [7:0]  page_q;
    logic [15:0] ptr0_q;
    logic [15:0] ptr1_q;
    logic [7:0]  index_q;
    logic [2:0]  div_q;
    logic [2:0]  div_cnt_q;
    logic        ce_q;
    logic [7:0]  rdata_q;
    logic [15:0] code_q;
    xmem_pkg::state_t  state_q;
    xmem_pkg::op_t     op_q;
    xmem_pkg::region_t region_q;
    logic        start_q;
    logic        done_q;
    logic        cmd_wr;
    logic        apb_wr;
    logic [15:0] active_ptr;
    logic [15:0] xaddr;

    xmem_timing_if tif ();

    function automatic xmem_pkg::region_t decode(input logic [15:0] a);
        if (a <= `GRAM_HI)
            decode = xmem_pkg::REGION_GRAM;
        else if (a >= `EDRAM_LO && a <= `EDRAM_HI)
            decode = xmem_pkg::REGION_EDRAM;
        else if (a >= `IORAM_LO && a <= `IORAM_HI)
            decode = xmem_pkg::REGION_IORAM;
        else if (a >= `EPRAM_LO && a <= `EPRAM_HI)
            decode = xmem_pkg::REGION_EPRAM;
        else
            decode = xmem_pkg::REGION_NONE;                             // [R4]
    endfunction

    assign apb_wr     = i_psel && i_penable && i_pwrite && o_pready;
    assign cmd_wr     = apb_wr && (i_paddr == `OFF_CMD) && (state_q == xmem_pkg::ST_IDLE);
    assign active_ptr = ptr_sel_q ? ptr1_q : ptr0_q;                   // [R12] [R13]

    // ----------------------------------------------------------------
    // Core clock divider
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            div_cnt_q <= 3'h0;
            ce_q      <= 1'b0;
        end
        else if (div_cnt_q >= div_q)
        begin
            div_cnt_q <= 3'h0;
            ce_q      <= 1'b1;                                          // [R14]
        end
        else
        begin
            div_cnt_q <= div_cnt_q + 3'h1;
            ce_q      <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            stretch_q <= `STRETCH_RST;                                  // [R9]
            ptr_sel_q <= 1'b0;
            page_q    <= 8'h00;
            index_q   <= 8'h00;
            div_q     <= 3'h0;
            code_q    <= `RESET_VECTOR;                                 // [R2]
        end
        else if (apb_wr)
        begin
            if (i_paddr == `OFF_STRETCH)
                stretch_q <= i_pwdata[2:0];                             // [R6]
            else if (i_paddr == `OFF_PTR_SEL)
                ptr_sel_q <= i_pwdata[0];                               // [R12]
            else if (i_paddr == `OFF_PAGE_HIGH)
                page_q <= i_pwdata[7:0];
            else if (i_paddr == `OFF_INDEX)
                index_q <= i_pwdata[7:0];
            else if (i_paddr == `OFF_CLK_DIV)
                div_q <= i_pwdata[2:0];                                 // [R14]
            else if (i_paddr == `OFF_CODE_ADDR)
                code_q <= i_pwdata[15:0];                               // [R1] [R3]
        end
    end

    // ----------------------------------------------------------------
    // Data pointers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ptr0_q <= 16'h0000;
            ptr1_q <= 16'h0000;
        end
        else if (apb_wr && i_paddr == `OFF_PTR0)
            ptr0_q <= i_pwdata[15:0];
        else if (apb_wr && i_paddr == `OFF_PTR1)
            ptr1_q <= i_pwdata[15:0];
        else if (cmd_wr)
        begin
            // Increment and load act on the selected pointer only
            if (i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB] == xmem_pkg::OP_PTR_INC)
            begin
                if (ptr_sel_q)
                    ptr1_q <= ptr1_q + 16'h0001;                        // [R13]
                else
                    ptr0_q <= ptr0_q + 16'h0001;                        // [R13]
            end
            else if (i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB] == xmem_pkg::OP_PTR_LOAD)
            begin
                if (ptr_sel_q)
                    ptr1_q <= i_pwdata[31:16];                          // [R13]
                else
                    ptr0_q <= i_pwdata[31:16];                          // [R13]
            end
        end
    end

    // ----------------------------------------------------------------
    // External move sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        if (i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB] == xmem_pkg::OP_READ_PAGED ||
            i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB] == xmem_pkg::OP_WRITE_PAGED)
            xaddr = {page_q, index_q};                                  // [R10]
        else
            xaddr = active_ptr;                                         // [R11]
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_q     <= xmem_pkg::ST_IDLE;
            op_q        <= xmem_pkg::OP_NONE;
            region_q    <= xmem_pkg::REGION_NONE;
            start_q     <= 1'b0;
            done_q      <= 1'b0;
            o_mem_addr  <= 16'h0000;
            o_mem_wdata <= 8'h00;
            rdata_q     <= 8'h00;
        end
        else
        begin
            start_q <= 1'b0;
            // Pin strobe lags the timer by one clock, so capture one clock late
            done_q  <= tif.done;
            case (state_q)
                xmem_pkg::ST_IDLE:
                begin
                    if (cmd_wr &&
                        i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB] != xmem_pkg::OP_NONE &&
                        i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB] != xmem_pkg::OP_PTR_INC &&
                        i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB] != xmem_pkg::OP_PTR_LOAD)
                    begin
                        op_q        <= xmem_pkg::op_t'(i_pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
                        o_mem_addr  <= xaddr;
                        o_mem_wdata <= i_pwdata[`CMD_DATA_MSB:`CMD_DATA_LSB];
                        region_q    <= decode(xaddr);
                        start_q     <= 1'b1;
                        state_q     <= xmem_pkg::ST_ADDR;
                    end
                end
                xmem_pkg::ST_ADDR:
                    state_q <= xmem_pkg::ST_HOLD;
                xmem_pkg::ST_HOLD:
                begin
                    if (done_q)
                    begin
                        // Unpopulated reads give a fixed harmless value
                        if (op_q == xmem_pkg::OP_READ_PAGED || op_q == xmem_pkg::OP_READ_PTR)
                            rdata_q <= (region_q == xmem_pkg::REGION_NONE) ?
                                       `UNMAPPED_DATA : i_mem_rdata;   // [R15]
                        op_q    <= xmem_pkg::OP_NONE;
                        state_q <= xmem_pkg::ST_IDLE;
                    end
                end
                default:
                    state_q <= xmem_pkg::ST_IDLE;
            endcase
        end
    end

    assign tif.start   = start_q;
    assign tif.write   = (op_q == xmem_pkg::OP_WRITE_PAGED) || (op_q == xmem_pkg::OP_WRITE_PTR); // [R5]
    assign tif.stretch = stretch_q;

    xmem_strobe_timer u_timer
    (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_ce  (ce_q),
        .tif   (tif)
    );

    // ----------------------------------------------------------------
    // Registered memory outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_mem_rd  <= 1'b0;
            o_mem_wr  <= 1'b0;
            o_mem_sel <= 5'h00;
        end
        else
        begin
            o_mem_rd  <= tif.strobe && !tif.write;                      // [R7]
            // Writes to holes reach no storage
            o_mem_wr  <= tif.strobe && tif.write &&
                         (region_q != xmem_pkg::REGION_NONE);           // [R5] [R15]
            o_mem_sel <= tif.addr_phase ? (5'h01 << region_q) : 5'h00;  // [R4]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_core_ce   <= 1'b0;
            o_code_addr <= `RESET_VECTOR;
        end
        else
        begin
            o_core_ce   <= ce_q;
            o_code_addr <= code_q;                                      // [R1] [R2]
        end
    end

    // ----------------------------------------------------------------
    // APB slave: one wait state, unmapped reads zero with error
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (i_psel && i_penable && !o_pready)
        begin
            o_pready  <= 1'b1;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            if (i_paddr == `OFF_STRETCH)
                o_prdata <= {29'h0, stretch_q};
            else if (i_paddr == `OFF_PTR_SEL)
                o_prdata <= {31'h0, ptr_sel_q};
            else if (i_paddr == `OFF_PAGE_HIGH)
                o_prdata <= {24'h0, page_q};
            else if (i_paddr == `OFF_PTR0)
                o_prdata <= {16'h0, ptr0_q};
            else if (i_paddr == `OFF_PTR1)
                o_prdata <= {16'h0, ptr1_q};
            else if (i_paddr == `OFF_INDEX)
                o_prdata <= {24'h0, index_q};
            else if (i_paddr == `OFF_CLK_DIV)
                o_prdata <= {29'h0, div_q};
            else if (i_paddr == `OFF_CMD)
                o_prdata <= 32'h0000_0000;
            else if (i_paddr == `OFF_STATUS)
                o_prdata <= {16'h0, rdata_q, 7'h0, (state_q != xmem_pkg::ST_IDLE)};
            else if (i_paddr == `OFF_CODE_ADDR)
                o_prdata <= {16'h0, code_q};
            else
                o_pslverr <= 1'b1;
        end
        else
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end
endmodule

// *** sim/xmem_controller_asserts.sv ***
// Port checks for the external memory controller
`timescale 1ns/1ps
`include "xmem_defs.svh"
module xmem_controller_asserts
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [7:0]  i_mem_rdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [15:0] o_mem_addr,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic        o_mem_rd,
    input wire logic        o_mem_wr,
    input wire logic [4:0]  o_mem_sel,
    input wire logic [15:0] o_code_addr,
    input wire logic        o_core_ce
);
    logic [2:0] stretch_q;
    logic [2:0] div_q;
    logic [3:0] rd_cnt_q;
    logic [3:0] wr_cnt_q;
    logic [3:0] sel_cnt_q;
    logic       was_wr_q;
    logic       reg_wr;
    assign reg_wr = i_psel && i_penable && i_pwrite && o_pready;
    function automatic logic [4:0] sel_of(input logic [15:0] a);
        if (a <= `GRAM_HI) return 5'h02;
        if (a >= `EDRAM_LO && a <= `EDRAM_HI) return 5'h04;
        if (a >= `IORAM_LO && a <= `IORAM_HI) return 5'h08;
        if (a >= `EPRAM_LO && a <= `EPRAM_HI) return 5'h10;
        return 5'h01;
    endfunction
    // Settings mirrored from bus writes; widths only judged at full core rate
    always_ff @(posedge i_clk)
    begin
        stretch_q <= i_rst ? 3'h1 : (reg_wr && i_paddr == `OFF_STRETCH) ? i_pwdata[2:0] : stretch_q;
        div_q     <= i_rst ? 3'h0 : (reg_wr && i_paddr == `OFF_CLK_DIV) ? i_pwdata[2:0] : div_q;
    end
    always_ff @(posedge i_clk)
    begin
        rd_cnt_q  <= (!i_rst && o_mem_rd) ? rd_cnt_q + 4'h1 : 4'h0;
        wr_cnt_q  <= (!i_rst && o_mem_wr) ? wr_cnt_q + 4'h1 : 4'h0;
        sel_cnt_q <= (!i_rst && |o_mem_sel) ? sel_cnt_q + 4'h1 : 4'h0;
        was_wr_q  <= (!i_rst && |o_mem_sel) ? (was_wr_q | o_mem_wr) : 1'b0;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_access;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_rd_end;
        $fell(o_mem_rd) && div_q == 3'h0;
    endsequence
    sequence s_wr_end;
        $fell(o_mem_wr) && div_q == 3'h0;
    endsequence
    sequence s_addr_end;
        $fell(|o_mem_sel) && $past(o_mem_sel) != 5'h01 && div_q == 3'h0;
    endsequence
    a_pready_answer: assert property (s_access |=> o_pready)
        else $error("no answer one cycle after access");
    a_pready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held two cycles");
    a_slverr_ready: assert property (o_pslverr |-> o_pready)
        else $error("error flag without ready");
    a_sel_decode: assert property (|o_mem_sel |-> o_mem_sel == sel_of(o_mem_addr))
        else $error("region select does not match address");
    a_wr_populated: assert property (o_mem_wr |-> sel_of(o_mem_addr) != 5'h01)
        else $error("write strobe to empty address");
    a_rd_wr_excl: assert property (!(o_mem_rd && o_mem_wr))
        else $error("read and write strobes together");
    a_rd_width: assert property (s_rd_end |-> rd_cnt_q == {1'b0, stretch_q} + 4'h1)
        else $error("read strobe width wrong");
    a_wr_width: assert property (s_wr_end |->
        wr_cnt_q == ((stretch_q == 3'h0) ? 4'h1 : {1'b0, stretch_q}))
        else $error("write strobe width wrong");
    a_addr_width: assert property (s_addr_end |->
        sel_cnt_q == {1'b0, stretch_q} + (was_wr_q ? 4'h2 : 4'h1))
        else $error("address phase width wrong");
    a_code_reset: assert property ($fell(i_rst) |-> o_code_addr == `RESET_VECTOR)
        else $error("program address not zero after reset");
endmodule
bind xmem_controller xmem_controller_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_mem_rdata(i_mem_rdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_sel(o_mem_sel), .o_code_addr(o_code_addr), .o_core_ce(o_core_ce));

// *** sim/xmem_mem_model.sv ***
// Behavioural model of the on-chip data memories
`timescale 1ns/1ps
`include "xmem_defs.svh"
module xmem_mem_model
(
    input  wire logic        i_clk,
    input  wire logic [15:0] i_mem_addr,
    input  wire logic [7:0]  i_mem_wdata,
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_wr,
    output logic      [7:0]  o_mem_rdata
);
    logic [7:0] mem_q [0:65535];
    logic [7:0] idle_q;
    logic       hit;
    assign hit = i_mem_addr <= `GRAM_HI
        || (i_mem_addr >= `EDRAM_LO && i_mem_addr <= `EDRAM_HI)
        || (i_mem_addr >= `IORAM_LO && i_mem_addr <= `IORAM_HI)
        || (i_mem_addr >= `EPRAM_LO && i_mem_addr <= `EPRAM_HI);
    // Read data follows the address while the strobe stands
    assign o_mem_rdata = i_mem_rd ? mem_q[i_mem_addr] : idle_q;
    initial
    begin
        idle_q = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem_q[i] = 8'(i) ^ 8'(i >> 8);
    end
    always @(posedge i_clk)
    begin
        if (i_mem_wr && hit) // Holes keep nothing
            mem_q[i_mem_addr] <= i_mem_wdata;
        idle_q <= ~idle_q; // Idle bus toggles so a stray sample is caught
    end
endmodule

// *** sim/xmem_controller_tb.sv ***
// Register-level testbench for the external memory controller
`timescale 1ns/1ps
`include "xmem_defs.svh"
module xmem_controller_tb;
    logic i_clk, i_rst, psel, penable, pwrite, mem_rd, mem_wr, pready, pslverr, core_ce;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  mem_rdata, mem_wdata, d;
    logic [15:0] mem_addr, code_addr;
    logic [4:0]  mem_sel;
    logic        e;
    int          err_total, cmp_count, n;
    xmem_controller dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_mem_rdata(mem_rdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_mem_addr(mem_addr),
        .o_mem_wdata(mem_wdata), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_sel(mem_sel),
        .o_code_addr(code_addr), .o_core_ce(core_ce));
    xmem_mem_model mem (.i_clk(i_clk), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
        .i_mem_rd(mem_rd), .i_mem_wr(mem_wr), .o_mem_rdata(mem_rdata));
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Setup a clock after the last release, then hold until ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int k;
        @(posedge i_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
        @(posedge i_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge i_clk); k++; end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) check(32'h0, 32'h1);
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // Command, then poll busy; the new command waits for idle
    task mv(input logic [2:0] op, input logic [7:0] wd, input logic [15:0] ld);
        int k;
        apb(1'b1, `OFF_CMD, {ld, wd, 5'h00, op});
        k = 0;
        q = 32'h1;
        while (q[0] !== 1'b0 && k < 200) begin apb(1'b0, `OFF_STATUS, 32'h0); k++; end
        if (k >= 200) check(32'h0, 32'h1);
        d = q[15:8];
    endtask
    initial
    begin
        #200000;
        err_total++;
        test_done;
    end
    initial
    begin
        err_total = 0; cmp_count = 0; i_rst = 1'b1;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(`OFF_STRETCH, 32'h1);
        rd_chk(`OFF_PTR_SEL, 32'h0);
        rd_chk(`OFF_PAGE_HIGH, 32'h0);
        check(code_addr, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        check({e, q[30:0]}, 32'h80000000);
        apb(1'b1, `OFF_CODE_ADDR, 32'h0001_FFFF);
        rd_chk(`OFF_CODE_ADDR, 32'hFFFF);
        check(code_addr, 32'hFFFF);
        $display("Reset and map test done");
        apb(1'b1, `OFF_PAGE_HIGH, 32'h10); apb(1'b1, `OFF_INDEX, 32'h05);
        mv(3'h3, 8'hA5, 16'h0);
        check(mem_addr, 32'h1005);
        mv(3'h1, 8'h00, 16'h0);
        check(d, 32'hA5);
        apb(1'b1, `OFF_PAGE_HIGH, 32'h20); apb(1'b1, `OFF_INDEX, 32'hFF);
        mv(3'h1, 8'h00, 16'h0);
        check(d, 32'hDF);
        $display("Paged test done");
        apb(1'b1, `OFF_PTR0, 32'h2010); apb(1'b1, `OFF_PTR1, 32'h3020);
        mv(3'h4, 8'h3C, 16'h0);
        check(mem_addr, 32'h2010);
        apb(1'b1, `OFF_PTR_SEL, 32'h1);
        mv(3'h4, 8'hC3, 16'h0);
        check(mem_addr, 32'h3020);
        mv(3'h2, 8'h00, 16'h0);
        check(d, 32'hC3);
        apb(1'b1, `OFF_PTR_SEL, 32'h0);
        mv(3'h2, 8'h00, 16'h0);
        check(d, 32'h3C);
        apb(1'b1, `OFF_PTR_SEL, 32'h1);
        mv(3'h5, 8'h00, 16'h0);
        rd_chk(`OFF_PTR1, 32'h3021);
        rd_chk(`OFF_PTR0, 32'h2010);
        mv(3'h6, 8'h00, 16'h0123);
        rd_chk(`OFF_PTR1, 32'h0123);
        mv(3'h2, 8'h00, 16'h0);
        check({mem_addr, 8'h00, d}, 32'h01230022);
        apb(1'b1, `OFF_PTR_SEL, 32'h0);
        $display("Pointer test done");
        for (n = 0; n < 8; n++)
        begin
            apb(1'b1, `OFF_STRETCH, n);
            rd_chk(`OFF_STRETCH, n);
            apb(1'b1, `OFF_PTR0, 32'h0100 + n);
            mv(3'h4, 8'h40 + 8'(n), 16'h0);
            mv(3'h2, 8'h00, 16'h0);
            check(d, 32'h40 + n);
        end
        $display("Stretch test done");
        apb(1'b1, `OFF_PTR0, 32'h0900);
        mv(3'h4, 8'h77, 16'h0);
        mv(3'h2, 8'h00, 16'h0);
        check(d, {24'h0, `UNMAPPED_DATA});
        $display("Hole test done");
        apb(1'b1, `OFF_CLK_DIV, 32'h3);
        repeat (8) @(negedge i_clk);
        n = 0;
        repeat (40) begin @(negedge i_clk); n += (core_ce === 1'b1); end
        check(n, 32'd10);
        $display("Divider test done");
        test_done;
    end
endmodule
